// [adc_flags_consts.svh]
// Offsets, field positions, reset values and launch codes of the converter status flags.
// Function
// - Primary ready sets on conversion or calibration done.
// - Primary ready clears directly or by a mode write that launches the primary converter.
// - Set primary ready locks result and coefficient writes.
// - Auxiliary ready mirrors primary ready for auxiliary converter.
// - Calibration flag sets when calibration finishes.
// - Calibration flag clears only on launching mode write.
// - Missing reference flag sets on bad reference.
// - Reference check runs only while a converter active.
// - Missing external reference forces results to ones.
// - Missing reference flag clears on valid reference.
// - Primary error sets when stored result clamped.
// - Primary error flags calibration that skipped coefficients.
// - Primary error clears on a mode write that launches the primary converter.
// - Auxiliary error mirrors primary error for auxiliary.
`ifndef ADC_FLAGS_CONSTS_SVH
`define ADC_FLAGS_CONSTS_SVH

// Byte offsets of the register words on the bus.
`define OFS_STATUS 12'h000
`define OFS_MODE 12'h004
`define OFS_CTRL 12'h008
`define OFS_IRQ_STAT 12'h00C
`define OFS_IRQ_MASK 12'h010
`define OFS_PRI_RES 12'h014
`define OFS_AUX_RES 12'h018

// Bit positions inside the converter status register.
`define BIT_PRI_RDY 7
`define BIT_AUX_RDY 6
`define BIT_CAL 5
`define BIT_NOREF 4
`define BIT_PRI_ERR 3
`define BIT_AUX_ERR 2

// Bit positions inside the mode register.
`define BIT_PRI_EN 5
`define BIT_AUX_EN 4
`define MODE_MSB 2

// Lowest mode code that launches a conversion or calibration.
`define MODE_FIRST_RUN 3'h2

// Bit position of the external reference select in the control register.
`define BIT_EXT_REF 0

// Reset values.
`define RST_STATUS 8'h00
`define RST_MODE 8'h00
`define RST_MASK 6'h00

`endif

// [adc_flags_pkg.sv]
// Types shared by the converter status flag logic.
package adc_flags_pkg;

   // Events reported by one converter datapath, each a one-cycle pulse.
   typedef struct packed {
      logic conv_done; // A conversion finished and its result is on result_in.
      logic cal_done; // A calibration cycle finished.
      logic clamped; // The finished conversion result hit all zeros or all ones.
      logic cal_fault; // The finished calibration could not produce coefficients.
   } conv_evt_s;

   // Whole state of the top level.
   typedef struct packed {
      logic cal; // Calibration complete flag.
      logic noref; // Missing reference flag.
      logic [5:0] irq_stat; // Sticky interrupt causes, same layout as status bits 7 to 2.
      logic [5:0] irq_mask; // Interrupt enables.
      logic [7:0] mode; // Mode register.
      logic ext_ref; // External reference selected.
      logic [31:0] rdata; // Read data presented in the access phase.
      logic slverr; // Error answer for the current access.
      logic [5:0] flags_q; // Flags of the previous cycle, for set-edge detection.
   } top_state_s;

   // State of the two-flop synchroniser.
   typedef struct packed {
      logic meta;
      logic sync;
   } sync_state_s;

endpackage : adc_flags_pkg

// [pin_sync2.sv]
// Two-flop synchroniser for one level coming from a pin.
`timescale 1ns/1ns
module pin_sync2 (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Level in and out.
   input wire logic level_in,
   output logic level_out
);

   adc_flags_pkg::sync_state_s st_ff; // Registered state.
   adc_flags_pkg::sync_state_s nxt_st; // Next state.

   // The first stage feeds only the second stage, so metastability never reaches logic.
   always_comb begin
      nxt_st.meta = level_in;
      nxt_st.sync = st_ff.meta;
   end

   // State register.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level_out = st_ff.sync;

endmodule : pin_sync2

// [conv_flag_unit.sv]
// Ready flag, error flag and locked result register of one converter.
`timescale 1ns/1ns
module conv_flag_unit #(
   parameter int RES_W = 16
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Datapath events and result.
   input wire adc_flags_pkg::conv_evt_s evt_in,
   input wire logic [RES_W-1:0] result_in,
   // Control from the register block.
   input wire logic start_in,
   input wire logic clear_ready_in,
   input wire logic force_ones_in,
   // Flags, stored result and coefficient write strobe.
   output logic ready_out,
   output logic error_out,
   output logic [RES_W-1:0] result_out,
   output logic coef_we_out
);

   // Whole state of the unit.
   typedef struct packed {
      logic ready;
      logic error;
      logic [RES_W-1:0] result;
   } unit_state_s;

   unit_state_s st_ff; // Registered state.
   unit_state_s nxt_st; // Next state.
   logic accept; // Datapath may write results and coefficients.
   logic conv_take; // A conversion result is stored this cycle.
   logic cal_take; // A calibration outcome is taken this cycle.
   logic err_set; // Error flag set condition.

   // Flag and result update; a set always wins over a clear arriving with it.
   always_comb begin
      nxt_st = st_ff;
      accept = !st_ff.ready;
      conv_take = evt_in.conv_done && accept;
      cal_take = evt_in.cal_done && accept;
      // A forced result counts as a clamped one, because the reader sees all ones either way.
      err_set = (conv_take && (evt_in.clamped || force_ones_in)) || (cal_take && evt_in.cal_fault);
      if (conv_take) begin
         nxt_st.result = force_ones_in ? {RES_W{1'b1}} : result_in;
      end
      if (evt_in.conv_done || evt_in.cal_done) begin
         nxt_st.ready = 1'b1;
      end else if (start_in || clear_ready_in) begin
         nxt_st.ready = 1'b0;
      end
      if (err_set) begin
         nxt_st.error = 1'b1;
      end else if (start_in) begin
         nxt_st.error = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign ready_out = st_ff.ready;
   assign error_out = st_ff.error;
   assign result_out = st_ff.result;
   // Coefficients are written only by a calibration that is accepted and fault free.
   assign coef_we_out = cal_take && !evt_in.cal_fault;

   a_result_locked: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      st_ff.ready |=> $stable(st_ff.result)) else $error("result changed while ready set");
   a_coef_locked: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      coef_we_out |-> !st_ff.ready && !evt_in.cal_fault) else $error("coefficient write while locked");
   a_ready_sets: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (evt_in.conv_done || evt_in.cal_done) |=> st_ff.ready) else $error("ready did not set");
   a_error_clears: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (start_in && !err_set) |=> !st_ff.error) else $error("error did not clear on launch");
   a_error_sets: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (evt_in.conv_done && !st_ff.ready && evt_in.clamped) |=> st_ff.error && st_ff.ready)
      else $error("clamped result did not flag error");

endmodule : conv_flag_unit

// [adc_status_flags.sv]
// Converter status register with APB access, mode launch decode and interrupt.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "adc_flags_consts.svh"
module adc_status_flags #(
   parameter int RES_W = 16
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic arst_n_in,
   // APB slave.
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Primary converter datapath.
   input wire adc_flags_pkg::conv_evt_s pri_evt_in,
   input wire logic [RES_W-1:0] pri_result_in,
   input wire logic pri_active_in,
   output logic pri_start_out,
   output logic pri_coef_we_out,
   output logic [RES_W-1:0] pri_result_out,
   // Auxiliary converter datapath.
   input wire adc_flags_pkg::conv_evt_s aux_evt_in,
   input wire logic [RES_W-1:0] aux_result_in,
   input wire logic aux_active_in,
   output logic aux_start_out,
   output logic aux_coef_we_out,
   output logic [RES_W-1:0] aux_result_out,
   // Reference detector pin, high while a reference input is floating or too low.
   input wire logic ref_bad_in,
   // Mode register value and interrupt.
   output logic [7:0] mode_out,
   output logic irq_out
);

   adc_flags_pkg::top_state_s st_ff; // Registered state.
   adc_flags_pkg::top_state_s nxt_st; // Next state.

   logic ref_bad_sync; // Reference detector after synchronisation.
   logic setup; // APB setup cycle.
   logic wr_acc; // Write taking effect at this edge.
   logic [7:0] wr_byte; // Low byte of the write data.
   logic launch; // Mode write with a running mode code.
   logic pri_start; // Launch of the primary converter.
   logic aux_start; // Launch of the auxiliary converter.
   logic pri_clr; // Direct clear of the primary ready flag.
   logic aux_clr; // Direct clear of the auxiliary ready flag.
   logic any_active; // At least one converter enabled and running.
   logic force_ones; // Results must read as all ones.
   logic pri_rdy; // Primary ready flag.
   logic aux_rdy; // Auxiliary ready flag.
   logic pri_err; // Primary error flag.
   logic aux_err; // Auxiliary error flag.
   logic [7:0] status; // Assembled converter status register.
   logic [5:0] flags; // Status bits 7 to 2.
   logic [5:0] flag_rise; // Flags that became set this cycle.
   logic [31:0] rd_mux; // Read data for the address in the setup cycle.
   logic rd_miss; // Setup address maps to no register.

   // The reference detector is asynchronous to the core clock.
   pin_sync2 u_ref_sync (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .level_in(ref_bad_in),
      .level_out(ref_bad_sync)
   );

   // Primary converter flags and result.
   conv_flag_unit #(
      .RES_W(RES_W)
   ) u_pri (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .evt_in(pri_evt_in),
      .result_in(pri_result_in),
      .start_in(pri_start),
      .clear_ready_in(pri_clr),
      .force_ones_in(force_ones),
      .ready_out(pri_rdy),
      .error_out(pri_err),
      .result_out(pri_result_out),
      .coef_we_out(pri_coef_we_out)
   );

   // Auxiliary converter flags and result, same behaviour as the primary.
   conv_flag_unit #(
      .RES_W(RES_W)
   ) u_aux (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .evt_in(aux_evt_in),
      .result_in(aux_result_in),
      .start_in(aux_start),
      .clear_ready_in(aux_clr),
      .force_ones_in(force_ones),
      .ready_out(aux_rdy),
      .error_out(aux_err),
      .result_out(aux_result_out),
      .coef_we_out(aux_coef_we_out)
   );

   // Bus decode and launch decode.
   // A write takes effect only at the access edge, so the launch pulse is one cycle wide.
   always_comb begin
      setup = psel_in && !penable_in;
      wr_acc = psel_in && penable_in && pwrite_in && !st_ff.slverr;
      wr_byte = pwdata_in[7:0];
      launch = wr_acc && (paddr_in == `OFS_MODE) && (wr_byte[`MODE_MSB:0] >= `MODE_FIRST_RUN);
      pri_start = launch && wr_byte[`BIT_PRI_EN];
      aux_start = launch && wr_byte[`BIT_AUX_EN];
      // Only the two ready bits accept a direct clear; a one clears them.
      pri_clr = wr_acc && (paddr_in == `OFS_STATUS) && wr_byte[`BIT_PRI_RDY];
      aux_clr = wr_acc && (paddr_in == `OFS_STATUS) && wr_byte[`BIT_AUX_RDY];
   end

   // Status assembly.
   // The reference check runs only while a converter is enabled and running, because an idle
   // front end leaves the reference pins undriven and would report a false fault.
   always_comb begin
      any_active = (st_ff.mode[`BIT_PRI_EN] && pri_active_in) || (st_ff.mode[`BIT_AUX_EN] && aux_active_in);
      force_ones = st_ff.noref && st_ff.ext_ref;
      status = `RST_STATUS;
      status[`BIT_PRI_RDY] = pri_rdy;
      status[`BIT_AUX_RDY] = aux_rdy;
      status[`BIT_CAL] = st_ff.cal;
      status[`BIT_NOREF] = st_ff.noref;
      status[`BIT_PRI_ERR] = pri_err;
      status[`BIT_AUX_ERR] = aux_err;
      // Bits 1 and 0 keep their zero from the reset value and have no storage.
      flags = status[7:2];
      flag_rise = flags & ~st_ff.flags_q;
   end

   // Read multiplexer, evaluated in the setup cycle.
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_miss = 1'b0;
      unique case (paddr_in)
         `OFS_STATUS: begin
            rd_mux[7:0] = status;
         end
         `OFS_MODE: begin
            rd_mux[7:0] = st_ff.mode;
         end
         `OFS_CTRL: begin
            rd_mux[`BIT_EXT_REF] = st_ff.ext_ref;
         end
         `OFS_IRQ_STAT: begin
            rd_mux[7:2] = st_ff.irq_stat;
         end
         `OFS_IRQ_MASK: begin
            rd_mux[7:2] = st_ff.irq_mask;
         end
         `OFS_PRI_RES: begin
            rd_mux[RES_W-1:0] = pri_result_out;
         end
         `OFS_AUX_RES: begin
            rd_mux[RES_W-1:0] = aux_result_out;
         end
         default: begin
            rd_miss = 1'b1;
         end
      endcase
   end

   // Next state of the register block.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.flags_q = flags;
      // Read data and the error answer are captured in the setup cycle for the access cycle.
      if (setup) begin
         nxt_st.rdata = rd_mux;
         nxt_st.slverr = rd_miss;
      end
      // Calibration complete; a finish in the launch cycle wins over the clear.
      if (pri_evt_in.cal_done || aux_evt_in.cal_done) begin
         nxt_st.cal = 1'b1;
      end else if (launch) begin
         nxt_st.cal = 1'b0;
      end
      // Missing reference follows the detector while active and holds otherwise.
      if (any_active) begin
         nxt_st.noref = ref_bad_sync;
      end
      // Register writes.
      if (wr_acc && (paddr_in == `OFS_MODE)) begin
         nxt_st.mode = wr_byte;
      end
      if (wr_acc && (paddr_in == `OFS_CTRL)) begin
         nxt_st.ext_ref = wr_byte[`BIT_EXT_REF];
      end
      if (wr_acc && (paddr_in == `OFS_IRQ_MASK)) begin
         nxt_st.irq_mask = wr_byte[7:2];
      end
      // Sticky causes: a write of one clears, a new rise in the same cycle still sets.
      if (wr_acc && (paddr_in == `OFS_IRQ_STAT)) begin
         nxt_st.irq_stat = st_ff.irq_stat & ~wr_byte[7:2];
      end
      nxt_st.irq_stat = nxt_st.irq_stat | flag_rise;
   end

   // State register.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '0;
         st_ff.mode <= `RST_MODE;
         st_ff.irq_mask <= `RST_MASK;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs; the bus always answers in the first access cycle.
   assign prdata_out = st_ff.rdata;
   assign pready_out = psel_in && penable_in;
   assign pslverr_out = psel_in && penable_in && st_ff.slverr;
   assign pri_start_out = pri_start;
   assign aux_start_out = aux_start;
   assign mode_out = st_ff.mode;
   assign irq_out = |(st_ff.irq_stat & st_ff.irq_mask);

   // Calibration flag is set one cycle after any calibration finishes.
   a_cal_sets: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (pri_evt_in.cal_done || aux_evt_in.cal_done) |=> st_ff.cal) else $error("calibration flag not set");

   // Calibration flag falls only after a launching mode write.
   a_cal_clear_cause: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (st_ff.cal && !nxt_st.cal) |-> launch) else $error("calibration flag cleared without launch");

   // Missing reference flag stays put while both converters are idle.
   a_noref_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !any_active |=> $stable(st_ff.noref)) else $error("reference flag moved while idle");

   // A bad reference seen by the synchroniser while active shows in the flag next cycle.
   a_noref_sets: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (any_active && ref_bad_sync) |=> st_ff.noref) else $error("reference flag not set");

   // A valid reference while active clears the flag next cycle.
   a_noref_clears: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (any_active && !ref_bad_sync) |=> !st_ff.noref) else $error("reference flag not cleared");

   // Stored primary results are all ones when forced.
   a_force_ones: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (force_ones && pri_evt_in.conv_done && !pri_rdy) |=> (pri_result_out == {RES_W{1'b1}}))
      else $error("result not forced to ones");

   // A launching write to the primary clears its ready flag unless a finish coincides.
   a_ready_launch: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (pri_start && !pri_evt_in.conv_done && !pri_evt_in.cal_done) |=> !pri_rdy)
      else $error("primary ready not cleared by launch");

   // A direct clear of the auxiliary ready flag works like the primary one.
   a_aux_ready_clear: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (aux_clr && !aux_evt_in.conv_done && !aux_evt_in.cal_done) |=> !aux_rdy)
      else $error("auxiliary ready not cleared");

   // Auxiliary error sets on a failed auxiliary calibration.
   a_aux_error: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (aux_evt_in.cal_done && aux_evt_in.cal_fault && !aux_rdy) |=> aux_err && !aux_coef_we_out)
      else $error("auxiliary calibration fault not flagged");

   // Reserved status bits read zero in every read answer.
   a_reserved_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (pready_out && !pwrite_in && paddr_in == `OFS_STATUS) |-> (prdata_out[1:0] == 2'h0))
      else $error("reserved bits not zero");

   // The interrupt follows the masked causes.
   a_irq_level: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      $rose(st_ff.irq_stat[5]) && st_ff.irq_mask[5] |-> irq_out) else $error("interrupt not raised");

endmodule : adc_status_flags

// [adc_status_flags_tb_top.sv]
// Self-checking testbench for the converter status flags behind an APB register port.
`timescale 1ns/1ns
`include "adc_flags_consts.svh"
module adc_status_flags_tb_top;
   // Clock, reset and APB request and response lines.
   logic clk_in;
   logic arst_n_in;
   logic psel_in;
   logic penable_in;
   logic pwrite_in;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   // Converter datapath stand-ins.
   adc_flags_pkg::conv_evt_s pri_evt_in;
   adc_flags_pkg::conv_evt_s aux_evt_in;
   logic [15:0] pri_result_in;
   logic [15:0] aux_result_in;
   logic pri_active_in;
   logic aux_active_in;
   logic pri_start_out;
   logic aux_start_out;
   logic pri_coef_we_out;
   logic aux_coef_we_out;
   logic [15:0] pri_result_out;
   logic [15:0] aux_result_out;
   logic ref_bad_in;
   logic [7:0] mode_out;
   logic irq_out;
   // Bookkeeping of the run.
   int n_fail = 0;
   int num_checks = 0;
   logic [31:0] rdata;
   logic slverr;
   logic [1:0] starts;
   logic coefw;

   adc_status_flags dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .pri_evt_in(pri_evt_in), .pri_result_in(pri_result_in),
      .pri_active_in(pri_active_in), .pri_start_out(pri_start_out), .pri_coef_we_out(pri_coef_we_out),
      .pri_result_out(pri_result_out), .aux_evt_in(aux_evt_in), .aux_result_in(aux_result_in),
      .aux_active_in(aux_active_in), .aux_start_out(aux_start_out), .aux_coef_we_out(aux_coef_we_out),
      .aux_result_out(aux_result_out), .ref_bad_in(ref_bad_in), .mode_out(mode_out), .irq_out(irq_out));

   // The clock toggles every 5 ns for a 100 MHz rate.
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // Compares one value; case inequality lets no unknown pass as a match.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; the request is held until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      // No wait count is assumed; a slave that never answers is left to the watchdog.
      do begin
         @(posedge clk_in);
      end while (pready_out !== 1'b1);
      rdata = prdata_out;
      slverr = pslverr_out;
      starts = {pri_start_out, aux_start_out};
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask : apb

   // Reads a register and compares it with the expected word.
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdata, exp);
   endtask : rd

   // Pulses one datapath event for a single cycle and notes the coefficient strobe.
   task automatic evt(input logic aux, input logic [3:0] e, input logic [15:0] r);
      if (aux) begin
         aux_evt_in <= adc_flags_pkg::conv_evt_s'(e);
         aux_result_in <= r;
      end else begin
         pri_evt_in <= adc_flags_pkg::conv_evt_s'(e);
         pri_result_in <= r;
      end
      @(posedge clk_in);
      // The strobe is taken at the edge that consumes the event, before the flags move.
      coefw = aux ? aux_coef_we_out : pri_coef_we_out;
      pri_evt_in <= 4'h0;
      aux_evt_in <= 4'h0;
      @(posedge clk_in);
   endtask : evt

   // Prints the counts and the verdict, then stops the run.
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   // The tests take about 150 cycles, so 200 us means a hang.
   initial begin
      #200000;
      n_fail++;
      give_verdict();
   end

   // Main sequence.
   initial begin
      arst_n_in = 1'b0;
      {psel_in, penable_in, pwrite_in, pri_active_in, aux_active_in, ref_bad_in} = 6'h00;
      paddr_in = 12'h000;
      pwdata_in = 32'h0000_0000;
      pri_evt_in = 4'h0;
      aux_evt_in = 4'h0;
      pri_result_in = 16'h0000;
      aux_result_in = 16'h0000;
      repeat (12) @(posedge clk_in);
      arst_n_in <= 1'b1;
      @(posedge clk_in);
      rd(`OFS_STATUS, 32'h0000_0000);
      // A finished conversion sets ready and stores the result; a second one is locked out.
      evt(1'b0, 4'h8, 16'h1234);
      rd(`OFS_STATUS, 32'h0000_0080);
      chk(32'(irq_out), 32'h0000_0000);
      apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0080);
      chk(32'(irq_out), 32'h0000_0001);
      evt(1'b0, 4'h8, 16'h5678);
      rd(`OFS_PRI_RES, 32'h0000_1234);
      // Writes without the ready bit change nothing; reserved bits stay zero.
      apb(1'b1, `OFS_STATUS, 32'h0000_007F);
      rd(`OFS_STATUS, 32'h0000_0080);
      apb(1'b1, `OFS_STATUS, 32'h0000_0083);
      rd(`OFS_STATUS, 32'h0000_0000);
      apb(1'b1, `OFS_IRQ_STAT, 32'h0000_00FC);
      chk(32'(irq_out), 32'h0000_0000);
      // A clamped auxiliary result raises auxiliary ready and error.
      evt(1'b1, 4'hA, 16'hFFFF);
      rd(`OFS_STATUS, 32'h0000_0044);
      rd(`OFS_AUX_RES, 32'h0000_FFFF);
      // A primary calibration writes coefficients and sets the calibration flag.
      evt(1'b0, 4'h4, 16'h0000);
      chk(32'(coefw), 32'h0000_0001);
      rd(`OFS_STATUS, 32'h0000_00E4);
      // A launching mode write starts both converters and clears the ready, calibration and error flags.
      apb(1'b1, `OFS_MODE, 32'h0000_0032);
      chk(32'(starts), 32'h0000_0003);
      chk(32'(mode_out), 32'h0000_0032);
      rd(`OFS_STATUS, 32'h0000_0000);
      // A faulty calibration skips the coefficients and flags an error.
      evt(1'b0, 4'h5, 16'h0000);
      chk(32'(coefw), 32'h0000_0000);
      rd(`OFS_STATUS, 32'h0000_00A8);
      evt(1'b0, 4'h4, 16'h0000);
      chk(32'(coefw), 32'h0000_0000);
      // Clearing ready or a non-launching mode leaves calibration and error flags set.
      apb(1'b1, `OFS_STATUS, 32'h0000_00C0);
      rd(`OFS_STATUS, 32'h0000_0028);
      apb(1'b1, `OFS_MODE, 32'h0000_0031);
      chk(32'(starts), 32'h0000_0000);
      rd(`OFS_STATUS, 32'h0000_0028);
      apb(1'b1, `OFS_MODE, 32'h0000_0022);
      chk(32'(starts), 32'h0000_0002);
      rd(`OFS_STATUS, 32'h0000_0000);
      // A bad reference is ignored while both converters are idle.
      ref_bad_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      rd(`OFS_STATUS, 32'h0000_0000);
      pri_active_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      rd(`OFS_STATUS, 32'h0000_0010);
      // With the external reference selected the result is forced to ones.
      apb(1'b1, `OFS_CTRL, 32'h0000_0001);
      evt(1'b0, 4'h8, 16'h0042);
      rd(`OFS_PRI_RES, 32'h0000_FFFF);
      chk(32'(pri_result_out), 32'h0000_FFFF);
      rd(`OFS_STATUS, 32'h0000_0098);
      ref_bad_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      rd(`OFS_STATUS, 32'h0000_0088);
      // A faulty auxiliary calibration flags the auxiliary error; a clean one writes coefficients.
      evt(1'b1, 4'h5, 16'h0000);
      chk(32'(coefw), 32'h0000_0000);
      rd(`OFS_STATUS, 32'h0000_00EC);
      apb(1'b1, `OFS_STATUS, 32'h0000_0040);
      evt(1'b1, 4'h4, 16'h0000);
      chk(32'(coefw), 32'h0000_0001);
      rd(`OFS_STATUS, 32'h0000_00EC);
      // An unmapped address answers with an error and zero data.
      rd(12'h01C, 32'h0000_0000);
      chk(32'(slverr), 32'h0000_0001);
      give_verdict();
   end
endmodule : adc_status_flags_tb_top
